//--- bench/rpf_checker.sv
`timescale 1ns/10ps

module rpf_checker (
	// Clock, reset, APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Packet side
	input wire logic rx_done,
	input wire logic rx_crc_ok,
	input wire logic rx_ack_req,
	input wire logic rx_is_ack,
	input wire logic tx_done,
	input wire logic tx_buf_loaded,
	input wire logic tx_start,
	input wire logic tx_ack_req,
	input wire logic [1:0] tx_seq,
	input wire logic rx_on,
	input wire logic rx_report,
	input wire logic rx_drop,
	input wire logic ack_send,
	input wire logic ack_payload,
	input wire logic gpio_dclk,
	input wire logic gpio_dout
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_req_sent;
		tx_done && tx_ack_req;
	endsequence
	sequence s_good_req;
		rx_done && rx_crc_ok && rx_ack_req && !rx_is_ack;
	endsequence

	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	a_report_cause: assert property (rx_report |-> $past(rx_done && !rx_is_ack))
		else $error("report without packet");
	a_drop_cause: assert property (rx_drop |-> $past(rx_done))
		else $error("drop without packet");
	a_one_verdict: assert property (!(rx_report && rx_drop))
		else $error("report and drop together");
	a_ack_cause: assert property (ack_send |-> $past(rx_done && rx_crc_ok && rx_ack_req))
		else $error("ack without request");
	a_ack_report: assert property (ack_send |-> rx_report)
		else $error("ack for unreported packet");
	a_pay_pair: assert property (ack_payload |-> ack_send && $past(tx_buf_loaded))
		else $error("payload ack without buffer");
	a_wait_ack: assert property (s_req_sent |=> rx_on)
		else $error("receiver not held for ack");
	a_seq_step: assert property ($changed(tx_seq) |-> tx_start && tx_seq == 2'($past(tx_seq) + 2'h1))
		else $error("sequence number step wrong");
	a_dout_fall: assert property ($changed(gpio_dout) |-> $fell(gpio_dclk))
		else $error("data out moved off clock fall");
	c_ack: cover property (s_good_req ##1 ack_send);
endmodule : rpf_checker

bind rpf_top rpf_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .rx_done(rx_done), .rx_crc_ok(rx_crc_ok), .rx_ack_req(rx_ack_req),
	.rx_is_ack(rx_is_ack), .tx_done(tx_done), .tx_buf_loaded(tx_buf_loaded),
	.tx_start(tx_start), .tx_ack_req(tx_ack_req), .tx_seq(tx_seq), .rx_on(rx_on),
	.rx_report(rx_report), .rx_drop(rx_drop), .ack_send(ack_send),
	.ack_payload(ack_payload), .gpio_dclk(gpio_dclk), .gpio_dout(gpio_dout));

//--- bench/rpf_peer.sv
`timescale 1ns/10ps

// ----------------------------------------
// Remote transceiver: ends frames, answers acks
// ----------------------------------------
module rpf_peer #(
	parameter int DLY = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Framer side
	input wire logic tx_start,
	input wire logic tx_ack_req,
	input wire logic ack_en,
	// Radio replies
	output logic tx_done,
	output logic ack_rx
);
	int cnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			tx_done <= 1'b0;
			ack_rx <= 1'b0;
		end else begin
			cnt <= tx_start ? DLY + 2 : (cnt > 0 ? cnt - 1 : 0);
			tx_done <= (cnt == 3);
			// Ack lands well inside the short wait window
			ack_rx <= (cnt == 1) && tx_ack_req && ack_en;
		end
	end
endmodule : rpf_peer

//--- bench/rpf_top_tb.sv
`timescale 1ns/10ps
`include "rpf_defs.svh"

module rpf_top_tb;
	logic pclk, presetn, psel, penable, pwrite, rx_done, rx_crc_ok, rx_ack_req, rx_is_ack;
	logic tx_done, tx_buf_loaded, gpio_din, rx_raw_bit, rx_raw_valid, ack_rx, ack_en;
	logic b_done, b_crc, b_isack, pready, pslverr, slv, tx_start, tx_ack_req, rx_on;
	logic rx_report, rx_drop, ack_send, ack_payload, tx_raw_fifo, tx_bit, tx_bit_valid;
	logic gpio_dclk, gpio_dout, rx_byte_wr;
	logic [1:0] tx_seq;
	logic [7:0] paddr, rx_dest, rx_src, rx_byte;
	logic [31:0] pwdata, prdata, rx_ctrl, rd;
	int err_total, samples_checked;
	typedef struct {logic [31:0] proto, fopt; logic crc; logic [7:0] d, s; logic [31:0] c;
		logic rep;} rpf_fcase_t;
	rpf_fcase_t fc[16] = '{
		'{32'h001, 32'h01, 0, 8'h11, 8'h0a, 32'h0f, 0},
		'{32'h000, 32'h3f, 0, 8'h44, 8'h5a, 32'hff, 1},
		'{32'h001, 32'h02, 1, 8'h22, 8'h0a, 32'h0f, 0},
		'{32'h001, 32'h02, 1, 8'h11, 8'h0a, 32'h0f, 1},
		'{32'h001, 32'h04, 1, 8'h22, 8'h0a, 32'h0f, 1},
		'{32'h001, 32'h04, 1, 8'h11, 8'h0a, 32'h0f, 0},
		'{32'h001, 32'h08, 1, 8'h33, 8'h0a, 32'h0f, 1},
		'{32'h001, 32'h08, 1, 8'h11, 8'h0a, 32'h0f, 0},
		'{32'h001, 32'h10, 1, 8'h11, 8'h5a, 32'h0f, 0},
		'{32'h001, 32'h10, 1, 8'h11, 8'h0a, 32'h0f, 1},
		'{32'h001, 32'h20, 1, 8'h11, 8'h0a, 32'hff, 0},
		'{32'h001, 32'h23, 1, 8'h11, 8'h0a, 32'h0f, 1},
		'{32'h001, 32'h23, 1, 8'h11, 8'h0a, 32'h1f, 0},
		'{32'h101, 32'h3f, 0, 8'h44, 8'h5a, 32'hff, 1},
		'{32'h201, 32'h10, 1, 8'h11, 8'h5a, 32'h0f, 1},
		'{32'h201, 32'h01, 0, 8'h11, 8'h0a, 32'h0f, 0}};

	// Peer acks ride on the same receive report lines
	assign rx_done = b_done | ack_rx;
	assign rx_crc_ok = b_crc | ack_rx;
	assign rx_is_ack = b_isack | ack_rx;

	rpf_top #(.DCLK_DIV(2)) dut (.*);
	rpf_peer #(.DLY(3)) peer (.clk(pclk), .rst_n(presetn), .tx_start(tx_start),
		.tx_ack_req(tx_ack_req), .ack_en(ack_en), .tx_done(tx_done), .ack_rx(ack_rx));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		if (err_total == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			err_total++;
			stop_test();
		end
	endtask : apb

	task automatic wait_hi(input int sel);
		int n;
		for (n = 0; n < 60 && (sel ? rx_byte_wr : tx_bit_valid) !== 1'b1; n++)
			@(posedge pclk);
		if (n == 60) begin
			err_total++;
			stop_test();
		end
	endtask : wait_hi

	task automatic pkt(input logic crc, input logic [7:0] d, s, input logic [31:0] c,
		input logic req);
		@(posedge pclk);
		b_done <= 1'b1;
		b_crc <= crc;
		rx_dest <= d;
		rx_src <= s;
		rx_ctrl <= c;
		rx_ack_req <= req;
		@(posedge pclk);
		b_done <= 1'b0;
		#1;
	endtask : pkt

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		apb(0, `RPF_OFS_PROTO, 0);
		check("proto reset", rd, `RPF_RST_WORD);
		apb(0, `RPF_OFS_TMO, 0);
		check("timeout reset", rd, 32'(`RPF_RST_TMO));
		apb(0, 8'h40, 0);
		check("unmapped", {slv, rd[30:0]}, 32'h8000_0000);
		apb(1, `RPF_OFS_FOPT, 32'h3f);
		apb(0, `RPF_OFS_FOPT, 0);
		check("options", rd, 32'h3f);
	endtask : t_regs

	task automatic t_filter();
		apb(1, `RPF_OFS_DADDR, 32'h0033_2211);
		apb(1, `RPF_OFS_SADDR, 32'h0000_0f5a);
		apb(1, `RPF_OFS_CREF, 32'h0000_00ff);
		apb(1, `RPF_OFS_CMASK, 32'h0000_000f);
		foreach (fc[i]) begin
			apb(1, `RPF_OFS_PROTO, fc[i].proto);
			apb(1, `RPF_OFS_FOPT, fc[i].fopt);
			pkt(fc[i].crc, fc[i].d, fc[i].s, fc[i].c, 1'b0);
			check("report", 32'(rx_report), 32'(fc[i].rep));
			check("drop", 32'(rx_drop), 32'(!fc[i].rep));
		end
	endtask : t_filter

	task automatic t_ack();
		apb(1, `RPF_OFS_PROTO, 32'h6);
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			tx_buf_loaded <= (i == 2);
			pkt(1'b1, 8'h11, 8'h0a, 32'h0f, i > 0);
			check("ack", 32'(ack_send), 32'(i > 0));
			check("ack payload", 32'(ack_payload), 32'(i == 2));
		end
	endtask : t_ack

	task automatic t_send(input logic ack, input int starts, input logic [31:0] stat);
		int n;
		n = 0;
		ack_en <= ack;
		tx_buf_loaded <= 1'b1;
		apb(1, `RPF_OFS_CMD, 32'h1);
		// Window far exceeds three attempts with a four cycle wait each
		repeat (100) begin
			@(posedge pclk);
			n += int'(tx_start === 1'b1);
		end
		check("starts", 32'(n), 32'(starts));
		check("request bit", 32'(tx_ack_req), 32'h1);
		apb(0, `RPF_OFS_STAT, 0);
		check("status", rd, stat);
		apb(1, `RPF_OFS_STAT, 32'h3);
	endtask : t_send

	task automatic t_direct();
		apb(1, `RPF_OFS_PCTRL, 32'h1);
		repeat (2) @(posedge pclk);
		check("raw fifo", 32'(tx_raw_fifo), 32'h1);
		gpio_din <= 1'b1;
		apb(1, `RPF_OFS_PCTRL, 32'h2);
		wait_hi(0);
		check("gpio bit", 32'(tx_bit), 32'h1);
		gpio_din <= 1'b0;
		apb(1, `RPF_OFS_PCTRL, 32'h3);
		check("raw fifo off", 32'(tx_raw_fifo), 32'h0);
		wait_hi(0);
		// Second pulse is surely from the sequence; all-ones seed leads with ones
		@(posedge pclk);
		wait_hi(0);
		check("pn9 bit", 32'(tx_bit), 32'h1);
		apb(1, `RPF_OFS_PCTRL, 32'h4);
		for (int i = 7; i >= 0; i--) begin
			@(posedge pclk);
			rx_raw_bit <= 1'(8'ha5 >> i);
			rx_raw_valid <= 1'b1;
			@(posedge pclk);
			rx_raw_valid <= 1'b0;
		end
		wait_hi(1);
		check("raw byte", 32'(rx_byte), 32'ha5);
		apb(1, `RPF_OFS_PCTRL, 32'h8);
		rx_raw_bit <= 1'b1;
		rx_raw_valid <= 1'b1;
		@(posedge pclk);
		rx_raw_valid <= 1'b0;
		repeat (12) @(posedge pclk);
		check("gpio out", 32'(gpio_dout), 32'h1);
	endtask : t_direct

	initial begin
		{psel, penable, pwrite, b_done, b_crc, b_isack, rx_ack_req, presetn} = '0;
		{tx_buf_loaded, gpio_din, rx_raw_bit, rx_raw_valid, ack_en} = '0;
		{paddr, rx_dest, rx_src} = '0;
		{pwdata, rx_ctrl} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_filter();
		t_ack();
		apb(1, `RPF_OFS_TMO, 32'h0101);
		apb(1, `RPF_OFS_PROTO, 32'h28);
		t_send(1'b0, 3, 32'h92);
		t_send(1'b1, 1, 32'h21);
		t_direct();
		stop_test();
	end

	initial begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule : rpf_top_tb

//--- hw/rpf_defs.svh
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RPF_OFS_PROTO 8'h00
`define RPF_OFS_FOPT 8'h04
`define RPF_OFS_DADDR 8'h08
`define RPF_OFS_SADDR 8'h0c
`define RPF_OFS_CREF 8'h10
`define RPF_OFS_CMASK 8'h14
`define RPF_OFS_PCTRL 8'h18
`define RPF_OFS_TMO 8'h1c
`define RPF_OFS_CMD 8'h20
`define RPF_OFS_STAT 8'h24

// ----------------------------------------
// Protocol register fields
// ----------------------------------------
`define RPF_P_FLT 0
`define RPF_P_AACK 1
`define RPF_P_APLD 2
`define RPF_P_AREQ 3
`define RPF_P_RETX_LO 4
`define RPF_P_FMT_LO 8

// ----------------------------------------
// Filter option fields
// ----------------------------------------
`define RPF_F_CRC 0
`define RPF_F_OWN 1
`define RPF_F_BCAST 2
`define RPF_F_MCAST 3
`define RPF_F_SRC 4
`define RPF_F_CTRL 5

// ----------------------------------------
// Command and status fields
// ----------------------------------------
`define RPF_C_SEND 0
`define RPF_S_SENT 0
`define RPF_S_LOST 1

// ----------------------------------------
// Codes, reset values, counts
// ----------------------------------------
`define RPF_FMT_LINK 2'h0
`define RPF_FMT_MBUS 2'h1
`define RPF_FMT_BASIC 2'h2
`define RPF_PATH_NORM 2'h0
`define RPF_PATH_FIFO 2'h1
`define RPF_PATH_GPIO 2'h2
`define RPF_PATH_PN9 2'h3
`define RPF_RST_WORD 32'h0000_0000
`define RPF_RST_TMO 16'h0f0f
`define RPF_DCLK_DIV 8
`define RPF_PN9_SEED 9'h1ff

`endif

//--- hw/rpf_pkg.sv
package rpf_pkg;

	// Link-layer sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEND,
		ST_WAIT_ACK
	} rpf_state_t;

	typedef logic [1:0] rpf_path_t;

endpackage : rpf_pkg

//--- hw/rpf_pn9.sv
`timescale 1ns/10ps
`include "rpf_defs.svh"

module rpf_pn9 (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic step,
	// Sequence out
	output logic bit_out
);

	logic [8:0] lfsr_r;

	// x^9 + x^5 + 1, never reaches all zeros from a non-zero seed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_r <= `RPF_PN9_SEED;
		end else if (step) begin
			lfsr_r <= {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
		end
	end

	assign bit_out = lfsr_r[8];

endmodule : rpf_pn9

//--- hw/rpf_top.sv
`timescale 1ns/10ps
`include "rpf_defs.svh"

// Behaviour
// - With filtering and checksum option on, drop packets failing the checksum.
// - Own-address option drops packets whose destination differs from own address.
// - Broadcast option drops packets whose destination differs from broadcast address.
// - Multicast option drops packets whose destination differs from multicast address.
// - Several filter options may be on together; all of them apply.
// - Source filter compares source against reference AND mask; mismatch drops.
// - Control filter compares control against reference AND mask; mismatch drops.
// - Link format allows all filters, meter-bus none, basic all but source.
// - Packet reported to host only when every enabled check passes.
// - Auto-ack sends an acknowledgement only for packets with request bit 1.
// - Outgoing request bit carries the configured acknowledge request setting.
// - After a requesting send, stay receiving until the receive timeout expires.
// - Missing acknowledgement means packet lost; sent flag stays 0.
// - With ack-payload enabled and buffer loaded, acknowledgement carries that payload.
// - Without acknowledgement, retransmit up to the configured retry count, max 15.
// - Transmit path: 0 framed, 1 raw buffer, 2 GPIO bits, 3 PN9.
// - GPIO transmit outputs data clock; data sampled on its rising edge.
// - Receive path: 0 deframed, 1 raw bytes to buffer, 2 raw bits to GPIO.
// - GPIO receive outputs data clock; data updated on its falling edge.
// - Keep 2-bit sequence number, incremented for every new packet.

module rpf_top #(
	parameter int DCLK_DIV = `RPF_DCLK_DIV
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Deframer report of a received packet
	input wire logic rx_done,
	input wire logic rx_crc_ok,
	input wire logic [7:0] rx_dest,
	input wire logic [7:0] rx_src,
	input wire logic [31:0] rx_ctrl,
	input wire logic rx_ack_req,
	input wire logic rx_is_ack,
	// Framer handshake
	input wire logic tx_done,
	input wire logic tx_buf_loaded,
	output logic tx_start,
	output logic tx_ack_req,
	output logic [1:0] tx_seq,
	output logic rx_on,
	output logic rx_report,
	output logic rx_drop,
	output logic ack_send,
	output logic ack_payload,
	// Direct data paths
	input wire logic gpio_din,
	input wire logic rx_raw_bit,
	input wire logic rx_raw_valid,
	output logic tx_raw_fifo,
	output logic tx_bit,
	output logic tx_bit_valid,
	output logic gpio_dclk,
	output logic gpio_dout,
	output logic [7:0] rx_byte,
	output logic rx_byte_wr
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] proto_r;
	logic [5:0] fopt_r;
	logic [23:0] daddr_r;
	logic [15:0] saddr_r;
	logic [31:0] cref_r;
	logic [31:0] cmask_r;
	logic [3:0] pctrl_r;
	logic [15:0] tmo_r;
	logic sent_r;
	logic lost_r;

	logic wr_en;
	logic [31:0] rd_nxt;
	logic rd_hit;
	logic send_cmd;
	logic sent_set;
	logic lost_set;
	rpf_pkg::rpf_state_t state_r;
	logic [3:0] retry_r;

	rpf_pkg::rpf_path_t tx_path;
	rpf_pkg::rpf_path_t rx_path;
	logic [1:0] fmt;
	logic [3:0] max_retry;

	assign tx_path = pctrl_r[1:0];
	assign rx_path = pctrl_r[3:2];
	assign fmt = proto_r[`RPF_P_FMT_LO +: 2];
	assign max_retry = proto_r[`RPF_P_RETX_LO +: 4];
	assign wr_en = psel & penable & pready & pwrite;
	assign send_cmd = wr_en && paddr == `RPF_OFS_CMD && pwdata[`RPF_C_SEND];

	// ----------------------------------------
	// APB slave, one wait-free access phase
	// ----------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		case (paddr)
			`RPF_OFS_PROTO: rd_nxt = proto_r;
			`RPF_OFS_FOPT: rd_nxt = {26'h0, fopt_r};
			`RPF_OFS_DADDR: rd_nxt = {8'h00, daddr_r};
			`RPF_OFS_SADDR: rd_nxt = {16'h0000, saddr_r};
			`RPF_OFS_CREF: rd_nxt = cref_r;
			`RPF_OFS_CMASK: rd_nxt = cmask_r;
			`RPF_OFS_PCTRL: rd_nxt = {28'h0, pctrl_r};
			`RPF_OFS_TMO: rd_nxt = {16'h0000, tmo_r};
			`RPF_OFS_CMD: rd_nxt = 32'h0000_0000;
			`RPF_OFS_STAT: rd_nxt = {22'h0, retry_r, tx_seq, 1'b0,
				state_r != rpf_pkg::ST_IDLE, lost_r, sent_r};
			default: rd_hit = 1'b0;
		endcase
	end

	// Ready comes up in the first access cycle, so every transfer is two cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_hit;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_nxt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proto_r <= `RPF_RST_WORD;
			fopt_r <= 6'h00;
			daddr_r <= 24'h000000;
			saddr_r <= 16'h0000;
			cref_r <= `RPF_RST_WORD;
			cmask_r <= `RPF_RST_WORD;
			pctrl_r <= 4'h0;
			tmo_r <= `RPF_RST_TMO;
		end else if (wr_en) begin
			case (paddr)
				`RPF_OFS_PROTO: proto_r <= {22'h0, pwdata[9:0]};
				`RPF_OFS_FOPT: fopt_r <= pwdata[5:0];
				`RPF_OFS_DADDR: daddr_r <= pwdata[23:0];
				`RPF_OFS_SADDR: saddr_r <= pwdata[15:0];
				`RPF_OFS_CREF: cref_r <= pwdata;
				`RPF_OFS_CMASK: cmask_r <= pwdata;
				`RPF_OFS_PCTRL: pctrl_r <= pwdata[3:0];
				`RPF_OFS_TMO: tmo_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Write one to clear; a fresh event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sent_r <= 1'b0;
			lost_r <= 1'b0;
		end else begin
			if (sent_set) begin
				sent_r <= 1'b1;
			end else if (wr_en && paddr == `RPF_OFS_STAT && pwdata[`RPF_S_SENT]) begin
				sent_r <= 1'b0;
			end
			if (lost_set) begin
				lost_r <= 1'b1;
			end else if (wr_en && paddr == `RPF_OFS_STAT && pwdata[`RPF_S_LOST]) begin
				lost_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Receive filter
	// ----------------------------------------
	logic flt_on;
	logic allow_src;
	logic pass_crc;
	logic pass_own;
	logic pass_bcast;
	logic pass_mcast;
	logic pass_src;
	logic pass_ctrl;
	logic accept;

	assign flt_on = proto_r[`RPF_P_FLT] && fmt != `RPF_FMT_MBUS;
	assign allow_src = fmt == `RPF_FMT_LINK;
	assign pass_crc = !fopt_r[`RPF_F_CRC] || rx_crc_ok;
	assign pass_own = !fopt_r[`RPF_F_OWN] || rx_dest == daddr_r[7:0];
	assign pass_bcast = !fopt_r[`RPF_F_BCAST] || rx_dest == daddr_r[15:8];
	assign pass_mcast = !fopt_r[`RPF_F_MCAST] || rx_dest == daddr_r[23:16];
	assign pass_src = !(fopt_r[`RPF_F_SRC] && allow_src)
		|| rx_src == (saddr_r[7:0] & saddr_r[15:8]);
	assign pass_ctrl = !fopt_r[`RPF_F_CTRL] || rx_ctrl == (cref_r & cmask_r);
	// Every enabled criterion must hold at once
	assign accept = !flt_on
		|| (pass_crc && pass_own && pass_bcast && pass_mcast && pass_src && pass_ctrl);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_report <= 1'b0;
			rx_drop <= 1'b0;
			ack_send <= 1'b0;
			ack_payload <= 1'b0;
		end else begin
			// Received acks are consumed by the sequencer, not the host
			rx_report <= rx_done && !rx_is_ack && rx_path == `RPF_PATH_NORM && accept;
			rx_drop <= rx_done && !rx_is_ack && rx_path == `RPF_PATH_NORM && !accept;
			ack_send <= rx_done && !rx_is_ack && accept && rx_crc_ok && rx_path == `RPF_PATH_NORM
				&& proto_r[`RPF_P_AACK] && rx_ack_req;
			ack_payload <= rx_done && !rx_is_ack && accept && rx_crc_ok && rx_path == `RPF_PATH_NORM
				&& proto_r[`RPF_P_AACK] && rx_ack_req
				&& proto_r[`RPF_P_APLD] && tx_buf_loaded;
		end
	end

	// ----------------------------------------
	// Link-layer sequencer
	// ----------------------------------------
	logic [7:0] pre_cnt_r;
	logic [7:0] tmo_cnt_r;
	logic tmo_hit;
	logic ack_ok;

	assign tmo_hit = pre_cnt_r == 8'h00 && tmo_cnt_r == 8'h00;
	assign ack_ok = rx_done && rx_is_ack && rx_crc_ok;
	assign sent_set = (state_r == rpf_pkg::ST_SEND && tx_done && !tx_ack_req)
		|| (state_r == rpf_pkg::ST_WAIT_ACK && ack_ok);
	assign lost_set = state_r == rpf_pkg::ST_WAIT_ACK && !ack_ok && tmo_hit
		&& retry_r >= max_retry;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= rpf_pkg::ST_IDLE;
			retry_r <= 4'h0;
			tx_seq <= 2'h0;
			tx_start <= 1'b0;
			tx_ack_req <= 1'b0;
		end else begin
			tx_start <= 1'b0;
			case (state_r)
				rpf_pkg::ST_IDLE: begin
					// Sending is only framed on the normal path
					if (send_cmd && tx_path == `RPF_PATH_NORM) begin
						tx_seq <= tx_seq + 2'h1;
						retry_r <= 4'h0;
						tx_ack_req <= proto_r[`RPF_P_AREQ];
						tx_start <= 1'b1;
						state_r <= rpf_pkg::ST_SEND;
					end
				end
				rpf_pkg::ST_SEND: begin
					if (tx_done) begin
						state_r <= tx_ack_req ? rpf_pkg::ST_WAIT_ACK : rpf_pkg::ST_IDLE;
					end
				end
				rpf_pkg::ST_WAIT_ACK: begin
					if (ack_ok) begin
						state_r <= rpf_pkg::ST_IDLE;
					end else if (tmo_hit) begin
						if (retry_r < max_retry) begin
							retry_r <= retry_r + 4'h1;
							tx_start <= 1'b1;
							state_r <= rpf_pkg::ST_SEND;
						end else begin
							state_r <= rpf_pkg::ST_IDLE;
						end
					end
				end
				default: state_r <= rpf_pkg::ST_IDLE;
			endcase
		end
	end

	// Timeout lasts (prescaler + 1) * (counter + 1) cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_r <= 8'h00;
			tmo_cnt_r <= 8'h00;
			rx_on <= 1'b0;
		end else begin
			rx_on <= (state_r == rpf_pkg::ST_SEND && tx_done && tx_ack_req)
				|| (state_r == rpf_pkg::ST_WAIT_ACK && !ack_ok && !tmo_hit);
			if (state_r != rpf_pkg::ST_WAIT_ACK) begin
				pre_cnt_r <= tmo_r[7:0];
				tmo_cnt_r <= tmo_r[15:8];
			end else if (pre_cnt_r != 8'h00) begin
				pre_cnt_r <= pre_cnt_r - 8'h01;
			end else if (tmo_cnt_r != 8'h00) begin
				pre_cnt_r <= tmo_r[7:0];
				tmo_cnt_r <= tmo_cnt_r - 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Direct data clock
	// ----------------------------------------
	logic [15:0] div_r;
	logic dclk_on;
	logic dclk_tick;
	logic rise;
	logic fall;

	assign dclk_on = tx_path == `RPF_PATH_GPIO || tx_path == `RPF_PATH_PN9
		|| rx_path == `RPF_PATH_GPIO;
	assign dclk_tick = dclk_on && div_r == 16'(DCLK_DIV - 1);
	assign rise = dclk_tick && !gpio_dclk;
	assign fall = dclk_tick && gpio_dclk;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 16'h0000;
			gpio_dclk <= 1'b0;
		end else if (!dclk_on) begin
			div_r <= 16'h0000;
			gpio_dclk <= 1'b0;
		end else begin
			div_r <= dclk_tick ? 16'h0000 : div_r + 16'h0001;
			if (dclk_tick) begin
				gpio_dclk <= !gpio_dclk;
			end
		end
	end

	// ----------------------------------------
	// Direct transmit paths
	// ----------------------------------------
	logic pn9_bit;

	rpf_pn9 u_pn9 (
		.clk(pclk),
		.rst_n(presetn),
		.step(rise && tx_path == `RPF_PATH_PN9),
		.bit_out(pn9_bit)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_raw_fifo <= 1'b0;
			tx_bit <= 1'b0;
			tx_bit_valid <= 1'b0;
		end else begin
			tx_raw_fifo <= tx_path == `RPF_PATH_FIFO;
			tx_bit_valid <= rise && (tx_path == `RPF_PATH_GPIO || tx_path == `RPF_PATH_PN9);
			if (rise && tx_path == `RPF_PATH_GPIO) begin
				tx_bit <= gpio_din;
			end else if (rise && tx_path == `RPF_PATH_PN9) begin
				tx_bit <= pn9_bit;
			end
		end
	end

	// ----------------------------------------
	// Direct receive paths
	// ----------------------------------------
	logic [7:0] shift_r;
	logic [2:0] bits_r;
	logic held_r;

	// No back-pressure: bytes are pushed out whether or not the host keeps up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_r <= 8'h00;
			bits_r <= 3'h0;
			rx_byte <= 8'h00;
			rx_byte_wr <= 1'b0;
		end else begin
			rx_byte_wr <= 1'b0;
			if (rx_path != `RPF_PATH_FIFO) begin
				bits_r <= 3'h0;
			end else if (rx_raw_valid) begin
				shift_r <= {shift_r[6:0], rx_raw_bit};
				bits_r <= bits_r + 3'h1;
				if (bits_r == 3'h7) begin
					rx_byte <= {shift_r[6:0], rx_raw_bit};
					rx_byte_wr <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_r <= 1'b0;
			gpio_dout <= 1'b0;
		end else begin
			if (rx_raw_valid) begin
				held_r <= rx_raw_bit;
			end
			if (fall && rx_path == `RPF_PATH_GPIO) begin
				gpio_dout <= held_r;
			end
		end
	end

endmodule : rpf_top
